// [hw/bbc_clock_calendar.sv]
// battery-backed clock-calendar: byte storage plus eight clock registers
// assumes host does 16-bit accesses, one-cycle strobes, synchronous bus
// What this block does
// - 8184 bytes of plain storage, then eight clock and control bytes
// - host clock accesses hit holding registers, not running counters
// - all time and date fields are bcd units and tens
// - control bit 6 freezes holding refresh; counters run; host clears
// - bit 7 freezes refresh; its clearing loads holding into counters
// - control bits 0-4 calibration magnitude, bit 5 sign positive
// - seconds bcd 0-59, bit 7 runs clock when one; minutes alike
// - hours bcd 00-23, always 24-hour form
// - weekday 1-7 advances with day; host loads correct value
// - century bit 4 toggles on year wrap when bit 5 set
// - weekday bit 6 enables 512 Hz square output
// - day of month bits 0-5, month bits 0-4 bcd
// - low-battery bit 6 read-only, updated at power cycle if bit 7
// - year bcd 00-99 wrapping to 00
`timescale 1ns/100ps
`include "bbc_consts.svh"
module bbc_clock_calendar #(
  parameter int unsigned TICK_CYCLES = `BBC_CLK_HZ / `BBC_TICK_HZ,
  parameter int unsigned SQW_HALF = `BBC_CLK_HZ / (2 * `BBC_OUT_HZ)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bbc_pkg::bbc_req_t req_i,
  input wire logic batt_low_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic sqw_o
);
  localparam int unsigned NV_WORDS = `BBC_NVRAM_BYTES;

  logic [7:0] nv_mem [NV_WORDS];
  bbc_pkg::bbc_time_t hold_reg;
  bbc_pkg::bbc_time_t hold_next;
  bbc_pkg::bbc_time_t cnt;
  logic [7:0] ctrl_reg;
  logic cen_en_reg;
  logic sqw_en_reg;
  logic batmon_reg;
  logic lowbat_reg;
  logic boot_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic sqw_reg;
  logic [31:0] tick_cnt_reg;
  logic [31:0] sqw_cnt_reg;
  logic load_reg;

  wire [28:0] a = req_i.addr;
  wire wr = req_i.sel && req_i.wr;
  wire rd = req_i.sel && !req_i.wr;
  wire [28:0] a_off = a - `BBC_BASE;
  wire in_nv = a >= `BBC_BASE && a < `BBC_REG_CTRL;
  wire [12:0] nv_idx = a_off[13:1];
  wire wr_ctrl = wr && a == `BBC_REG_CTRL;
  wire wr_sec = wr && a == `BBC_REG_SEC;
  wire wr_min = wr && a == `BBC_REG_MIN;
  wire wr_hour = wr && a == `BBC_REG_HOUR;
  wire wr_wday = wr && a == `BBC_REG_WDAY;
  wire wr_mday = wr && a == `BBC_REG_MDAY;
  wire wr_mon = wr && a == `BBC_REG_MON;
  wire wr_year = wr && a == `BBC_REG_YEAR;
  wire [7:0] wd = req_i.wdata;
  wire rd_lock = ctrl_reg[`BBC_CTRL_RDLOCK];
  wire wr_lock = ctrl_reg[`BBC_CTRL_WRLOCK];
  wire running = hold_reg.sec[`BBC_SEC_RUN];

  // signed calibration trim of the second period
  wire [4:0] cal_mag = ctrl_reg[4:0];
  wire cal_pos = ctrl_reg[`BBC_CTRL_SIGN];
  wire [31:0] cal_adj = 32'(cal_mag) * 32'(`BBC_CAL_STEP);
  wire [31:0] tick_len = cal_pos ? TICK_CYCLES - cal_adj
                                 : TICK_CYCLES + cal_adj;
  // stop flag gates the time base
  wire tick = running && tick_cnt_reg >= tick_len - 32'h1;
  wire load_now = wr_ctrl && wr_lock && !wd[`BBC_CTRL_WRLOCK];

  bbc_pkg::bbc_time_t load_val;
  always_comb begin
    load_val = hold_reg;
    load_val.sec[`BBC_SEC_RUN] = running;
  end

  bbc_counter i_bbc_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .cen_en_i(cen_en_reg),
    .load_i(load_reg),
    .load_val_i(load_val),
    .cnt_o(cnt)
  );

  // refresh only while neither lock is set
  wire refresh = !rd_lock && !wr_lock && !load_reg;

  // host writes land in holding registers
  always_comb begin
    hold_next = hold_reg;
    if (refresh) begin
      hold_next = cnt;
      hold_next.sec[`BBC_SEC_RUN] = running;
    end
    // stop bit is never refreshed away
    if (wr_sec) hold_next.sec = {wd[7], wd[6:0] & 7'h7F};
    if (wr_min) hold_next.min = {1'b0, wd[6:0]};
    if (wr_hour) hold_next.hour = {2'h0, wd[5:0]};
    if (wr_wday) begin
      hold_next.wday = wd[2:0];
      hold_next.cent = wd[`BBC_WDAY_CENT];
    end
    if (wr_mday) hold_next.mday = {2'h0, wd[5:0]};
    if (wr_mon) hold_next.mon = {3'h0, wd[4:0]};
    if (wr_year) hold_next.year = wd;
  end

  // bcd read mux on low byte lane
  logic [7:0] reg_rd;
  always_comb begin
    case (a)
      `BBC_REG_CTRL: reg_rd = ctrl_reg;
      `BBC_REG_SEC: reg_rd = hold_reg.sec;
      `BBC_REG_MIN: reg_rd = hold_reg.min;
      `BBC_REG_HOUR: reg_rd = hold_reg.hour;
      `BBC_REG_WDAY: reg_rd = {1'b0, sqw_en_reg, cen_en_reg, hold_reg.cent,
                               1'b0, hold_reg.wday};
      `BBC_REG_MDAY: reg_rd = {batmon_reg, lowbat_reg, hold_reg.mday[5:0]};
      `BBC_REG_MON: reg_rd = hold_reg.mon;
      `BBC_REG_YEAR: reg_rd = hold_reg.year;
      default: reg_rd = in_nv ? nv_mem[nv_idx] : 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (wr && in_nv) begin
      nv_mem[nv_idx] <= wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_reg <= '{8'h80, 8'h00, 8'h00, 3'h1, 1'b0, 8'h01, 8'h01, 8'h00};
      ctrl_reg <= 8'h00;
      cen_en_reg <= 1'b0;
      sqw_en_reg <= 1'b0;
      load_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      load_reg <= load_now;
      // lock bits held until host clears
      if (wr_ctrl) ctrl_reg <= wd;
      if (wr_wday) cen_en_reg <= wd[`BBC_WDAY_CEN_EN];
      if (wr_wday) sqw_en_reg <= wd[`BBC_WDAY_SQW_EN];
      rvalid_reg <= rd;
      if (rd) rdata_reg <= reg_rd;
    end
  end

  // monitor enable battery-backed
  // no reset: it must outlive the power cycle that it qualifies
  always_ff @(posedge clk_i) begin
    if (wr_mday) begin
      batmon_reg <= wd[`BBC_MDAY_BATMON];
    end
  end

  // sample battery once after power-up if monitoring enabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_reg <= 1'b1;
      lowbat_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg && batmon_reg) lowbat_reg <= batt_low_i;
    end
  end

  // one-second time base, restarts on load
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick || load_reg) begin
      tick_cnt_reg <= 32'h0;
    end else if (running) begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sqw_en_reg) begin
      sqw_cnt_reg <= 32'h0;
      sqw_reg <= 1'b0;
    end else if (sqw_cnt_reg >= SQW_HALF - 1) begin
      sqw_cnt_reg <= 32'h0;
      sqw_reg <= ~sqw_reg;
    end else begin
      sqw_cnt_reg <= sqw_cnt_reg + 32'h1;
    end
  end

  assign rdata_o = {8'h00, rdata_reg};
  assign rvalid_o = rvalid_reg;
  assign sqw_o = sqw_reg;
endmodule : bbc_clock_calendar

// [hw/bbc_counter.sv]
// running time counters with bcd carry chain
// assumes one-cycle tick and load pulses from the main block
`timescale 1ns/100ps
`include "bbc_consts.svh"
module bbc_counter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic cen_en_i,
  input wire logic load_i,
  input wire bbc_pkg::bbc_time_t load_val_i,
  output bbc_pkg::bbc_time_t cnt_o
);
  bbc_pkg::bbc_time_t cnt_reg;
  bbc_pkg::bbc_time_t cnt_next;

  // bcd increment with wrap to lo at hi
  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
      input logic [7:0] hi, input logic [7:0] lo);
    if (v == hi)
      bcd_inc = lo;
    else if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // last day of month in bcd, leap every fourth year
  function automatic logic [7:0] mlen(input logic [7:0] m,
      input logic [7:0] y);
    case (m)
      8'h02: mlen = (y[4] ? (y[1:0] == 2'h2) : (y[1:0] == 2'h0))
                    ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mlen = 8'h30;
      default: mlen = 8'h31;
    endcase
  endfunction : mlen

  wire c_sec = cnt_reg.sec[6:0] == 7'h59;
  wire c_min = c_sec && cnt_reg.min[6:0] == 7'h59;
  wire c_hr = c_min && cnt_reg.hour[5:0] == 6'h23;
  wire c_day = c_hr &&
      {2'h0, cnt_reg.mday[5:0]} == mlen(cnt_reg.mon, cnt_reg.year);
  wire c_mon = c_day && cnt_reg.mon[4:0] == 5'h12;
  wire c_yr = c_mon && cnt_reg.year == 8'h99;
  wire [7:0] sec_inc = bcd_inc({1'b0, cnt_reg.sec[6:0]}, 8'h59, 8'h00);
  wire [7:0] mday_inc = bcd_inc({2'h0, cnt_reg.mday[5:0]},
      mlen(cnt_reg.mon, cnt_reg.year), 8'h01);
  wire [7:0] mon_inc = bcd_inc({3'h0, cnt_reg.mon[4:0]}, 8'h12, 8'h01);

  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = load_val_i;
    end else if (tick_i) begin
      cnt_next.sec = {cnt_reg.sec[7], sec_inc[6:0]};
      if (c_sec) cnt_next.min = bcd_inc(cnt_reg.min, 8'h59, 8'h00);
      if (c_min) cnt_next.hour = bcd_inc(cnt_reg.hour, 8'h23, 8'h00);
      if (c_hr) begin
        cnt_next.wday = (cnt_reg.wday == 3'h7) ? 3'h1 : cnt_reg.wday + 3'h1;
        cnt_next.mday[5:0] = mday_inc[5:0];
      end
      if (c_day) cnt_next.mon[4:0] = mon_inc[4:0];
      if (c_mon) cnt_next.year = bcd_inc(cnt_reg.year, 8'h99, 8'h00);
      if (c_yr && cen_en_i) cnt_next.cent = ~cnt_reg.cent;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '{8'h00, 8'h00, 8'h00, 3'h1, 1'b0, 8'h01, 8'h01, 8'h00};
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign cnt_o = cnt_reg;
endmodule : bbc_counter

// [inc/bbc_consts.svh]
// constants for the battery-backed clock-calendar
// assumes 16-bit host bus, device on low byte lane
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
`define BBC_CLK_HZ 10000000
`define BBC_TICK_HZ 1
`define BBC_OUT_HZ 512
`define BBC_BASE 29'h1F620000
`define BBC_NVRAM_BYTES 8184
`define BBC_REG_CTRL 29'h1F623FF0
`define BBC_REG_SEC 29'h1F623FF2
`define BBC_REG_MIN 29'h1F623FF4
`define BBC_REG_HOUR 29'h1F623FF6
`define BBC_REG_WDAY 29'h1F623FF8
`define BBC_REG_MDAY 29'h1F623FFA
`define BBC_REG_MON 29'h1F623FFC
`define BBC_REG_YEAR 29'h1F623FFE
`define BBC_CTRL_RDLOCK 6
`define BBC_CTRL_WRLOCK 7
`define BBC_CTRL_SIGN 5
`define BBC_SEC_RUN 7
`define BBC_WDAY_CENT 4
`define BBC_WDAY_CEN_EN 5
`define BBC_WDAY_SQW_EN 6
`define BBC_MDAY_LOWBAT 6
`define BBC_MDAY_BATMON 7
`define BBC_CAL_STEP 16'h0040
`endif

// [inc/bbc_pkg.sv]
// types for the clock-calendar
// assumes bbc_consts.svh alongside
package bbc_pkg;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic cent;
    logic [7:0] mday;
    logic [7:0] mon;
    logic [7:0] year;
  } bbc_time_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [28:0] addr;
    logic [7:0] wdata;
  } bbc_req_t;
endpackage : bbc_pkg

// [tb/bbc_clock_calendar_asserts.sv]
// assertions on the clock-calendar host port
// assumes bind to the top module with its sim parameters
`timescale 1ns/100ps
`include "bbc_consts.svh"
module bbc_cc_asserts #(
  parameter int unsigned TICK_CYCLES = 20,
  parameter int unsigned SQW_HALF = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bbc_pkg::bbc_req_t req_i,
  input wire logic batt_low_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic sqw_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] hi_cnt;
  wire logic rd = req_i.sel && !req_i.wr;
  wire logic wr = req_i.sel && req_i.wr;
  always_ff @(posedge clk_i) hi_cnt <= sqw_o ? hi_cnt + 16'h0001 : 16'h0000;
  sequence s_store_wr;
    wr && req_i.addr >= `BBC_BASE && req_i.addr < `BBC_REG_CTRL;
  endsequence
  sequence s_same_rd;
    rd && req_i.addr == $past(req_i.addr, 2);
  endsequence
  a_read_answer:
    assert property (rd |=> rvalid_o && rdata_o[15:8] == 8'h00)
    else $error("read not answered on low lane");
  a_no_stray_valid:
    assert property (!rd |=> !rvalid_o) else $error("stray read valid");
  a_store_back:
    assert property (s_store_wr ##2 s_same_rd |=>
      rdata_o[7:0] == $past(req_i.wdata, 3)) else $error("storage lost");
  a_unmapped_zero:
    assert property (rd && req_i.addr >= `BBC_BASE + 29'h4000 |=>
      rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_sec_bcd:
    assert property (rd && req_i.addr == `BBC_REG_SEC |=>
      rdata_o[3:0] <= 4'h9 && rdata_o[6:4] <= 3'h5) else $error("bad sec");
  a_hour_range:
    assert property (rd && req_i.addr == `BBC_REG_HOUR |=>
      rdata_o[7:0] <= 8'h23 && rdata_o[3:0] <= 4'h9) else $error("bad hour");
  a_sqw_half:
    assert property (hi_cnt <= SQW_HALF) else $error("square high too long");
  a_sqw_off:
    assert property (wr && req_i.addr == `BBC_REG_WDAY && !req_i.wdata[6]
      |=> ##1 !sqw_o [*4]) else $error("square output not stopped");
endmodule : bbc_cc_asserts
bind bbc_clock_calendar bbc_cc_asserts #(.TICK_CYCLES(TICK_CYCLES),
  .SQW_HALF(SQW_HALF)) i_bbc_cc_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .req_i(req_i), .batt_low_i(batt_low_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .sqw_o(sqw_o));

// [tb/bbc_clock_calendar_tb_top.sv]
// self-checking bench for the clock-calendar
// assumes shortened tick and square-wave counts
`timescale 1ns/100ps
`include "bbc_consts.svh"
module bbc_clock_calendar_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic batt_low_i = 1'b0;
  bbc_pkg::bbc_req_t req;
  logic [15:0] rdata;
  logic [7:0] rbyte, d;
  logic rvalid, sqw, b;
  logic [28:0] a;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  localparam logic [28:0] RA[6] = '{`BBC_REG_MIN, `BBC_REG_HOUR,
    `BBC_REG_WDAY, `BBC_REG_MDAY, `BBC_REG_MON, `BBC_REG_YEAR};
  localparam logic [7:0] RV[6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] SW[6] = '{8'h59, 8'h23, 8'h27, 8'h31, 8'h12, 8'h99};
  localparam logic [7:0] RE[6] = '{8'h00, 8'h00, 8'h31, 8'h01, 8'h01, 8'h00};
  always #50 clk_i = ~clk_i;
  // tick long enough that full calibration cannot underflow it
  bbc_clock_calendar #(.TICK_CYCLES(2500), .SQW_HALF(4)) i_bbc_clock_calendar (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .batt_low_i(batt_low_i),
    .rdata_o(rdata), .rvalid_o(rvalid), .sqw_o(sqw));
  bbc_host_model i_bbc_host_model (.clk_i(clk_i), .rdata_i(rdata),
    .req_o(req), .rbyte_o(rbyte));
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [28:0] ad, input logic [7:0] dt);
    i_bbc_host_model.access(1'b1, ad, dt);
  endtask : wr
  task automatic rd(input logic [28:0] ad, input logic [7:0] ex);
    exp_q.push_back(ex);
    i_bbc_host_model.access(1'b0, ad, 8'h00);
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  always @(negedge clk_i) begin
    if (rvalid === 1'b1 && exp_q.size() > 0) cmp(exp_q.pop_front(), rbyte);
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    void'($urandom(94796));
    // battery-backed monitor bit is unknown at first power-up
    wr(`BBC_REG_MDAY, 8'h00);
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    batt_low_i <= 1'($urandom);
    foreach (RA[i]) rd(RA[i], RV[i]);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      // one storage byte per 16-bit word, so even addresses only
      a = `BBC_BASE + 29'(((i == 0) ? `BBC_NVRAM_BYTES - 1
                                   : $urandom_range(`BBC_NVRAM_BYTES - 2)) * 2);
      d = 8'($urandom);
      wr(a, d);
      rd(a, d);
    end
    rd(`BBC_BASE + 29'h4000, 8'h00);
    $display("test storage done");
    wr(`BBC_REG_CTRL, 8'h25);
    rd(`BBC_REG_CTRL, 8'h25);
    wr(`BBC_REG_CTRL, 8'h80);
    wr(`BBC_REG_HOUR, 8'hE3);
    rd(`BBC_REG_HOUR, 8'h23);
    wr(`BBC_REG_SEC, 8'hD9);
    foreach (RA[i]) wr(RA[i], SW[i]);
    wr(`BBC_REG_CTRL, 8'h00);
    repeat (2600) @(posedge clk_i);
    wr(`BBC_REG_CTRL, 8'h40);
    foreach (RA[i]) rd(RA[i], RE[i]);
    $display("test rollover done");
    wr(`BBC_REG_CTRL, 8'hC0);
    wr(`BBC_REG_SEC, 8'h95);
    wr(`BBC_REG_CTRL, 8'h40);
    repeat (2600) @(posedge clk_i);
    rd(`BBC_REG_SEC, 8'h95);
    wr(`BBC_REG_CTRL, 8'h00);
    rd(`BBC_REG_SEC, 8'h96);
    wr(`BBC_REG_CTRL, 8'h80);
    wr(`BBC_REG_SEC, 8'h30);
    wr(`BBC_REG_CTRL, 8'h00);
    repeat (2600) @(posedge clk_i);
    rd(`BBC_REG_SEC, 8'h30);
    $display("test freeze and stop done");
    wr(`BBC_REG_WDAY, 8'h41);
    repeat (10) @(posedge clk_i);
    #1;
    n = 0;
    repeat (32) begin
      b = sqw;
      @(posedge clk_i);
      #1 n += int'(sqw != b);
    end
    cmp(8'h08, 8'(n));
    wr(`BBC_REG_WDAY, 8'h01);
    repeat (6) @(posedge clk_i);
    #1 cmp(8'h00, {7'h00, sqw});
    $display("test square output done");
    wr(`BBC_REG_CTRL, 8'h80);
    wr(`BBC_REG_MDAY, 8'hC1);
    rd(`BBC_REG_MDAY, 8'h81);
    wr(`BBC_REG_CTRL, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    b = 1'($urandom);
    batt_low_i <= b;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`BBC_REG_MIN, 8'h00);
    rd(`BBC_REG_MDAY, {1'b1, b, 6'h01});
    repeat (4) @(posedge clk_i);
    cmp(8'h00, 8'(exp_q.size()));
    $display("test battery done");
    conclude();
  end
endmodule : bbc_clock_calendar_tb_top

// [tb/bbc_host_model.sv]
// host processor model on the 16-bit bus
// assumes the bench calls access once per bus cycle
`timescale 1ns/100ps
module bbc_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output bbc_pkg::bbc_req_t req_o,
  output logic [7:0] rbyte_o
);
  assign rbyte_o = rdata_i[7:0];
  initial req_o = '0;
  // one access per byte, callers may pass reserved bits as one
  task automatic access(input logic w, input logic [28:0] a,
                        input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{1'b1, w, a, d};
    @(posedge clk_i);
    // released lines show garbage, not the last value
    req_o <= '{1'b0, ~w, ~a, ~d};
  endtask : access
endmodule : bbc_host_model
